// ==== hdl/acpc_defs.svh ====
// Purpose: constants of the converter control block
// Assumes: 32-bit AHB-Lite word registers, 125 MHz clk
// Notes:   one word per register
// How it works
// - converter held off during reset or when channel select is all ones
// - after a conversion and before the next, converter idles in low power
// - raw value is 12 bits in 12/10-bit modes, 9 bits in 8-bit mode
// - 10-bit rounds into both result registers, 8-bit only the low one
// - after result write set done flag, interrupt if enabled
// - compare enable checks every result against the compare value
// - clock source is bus, bus halved, alternate or internal clock
// - clock source resets to the undivided bus clock
// - selected source divided by 1, 2, 4 or 8
// - halved bus with divide by 8 gives a bus division of 16
// - internal clock keeps running in wait and stop3 modes
// - mid pin register bits 7..0 govern channels 15..8
// - top pin register bits 7..0 govern channels 23..16
// - pin bit 0 leaves port control, 1 removes it
// - pin bit set forces the output driver high impedance
// - pin bit set disables input buffer, port reads zero
// - pin bit set switches the pull-up off
// - with trigger enable set, trigger rising edge starts a conversion
// - trigger edge during a conversion is ignored
// - in continuous mode only the first trigger edge counts
// - trigger works with every mode and configuration except stop mode without the internal clock source
// - resolution 12, 10 or 8 bits; software or hardware start
// - source codes 00 bus, 01 halved, 10 alternate, 11 internal
// - divide codes 00 /1, 01 /2, 10 /4, 11 /8
// - resolution codes 00 8-bit, 01 12-bit, 10 10-bit, 11 reserved
// - software mode write of status/control with valid channel starts
`ifndef ACPC_DEFS_SVH
`define ACPC_DEFS_SVH
`define A_SC1        6'h00
`define A_SC2        6'h04
`define A_RES_H      6'h08
`define A_RES_L      6'h0c
`define A_CV_H       6'h10
`define A_CV_L       6'h14
`define A_CFG        6'h18
`define A_PIN_MID    6'h1c
`define A_PIN_TOP    6'h20
`define CH_OFF       5'h1f
`define SRC_BUS      2'b00
`define SRC_HALF     2'b01
`define SRC_ALT      2'b10
`define SRC_INT      2'b11
`define RES_8        2'b00
`define RES_12       2'b01
`define RES_10       2'b10
`define DIV_8        2'b11
`define CLK_NS       8
`define INT_CLK_NS   400
`define INT_CLK_CYC  (`INT_CLK_NS / `CLK_NS)
`endif

// ==== hdl/acpc_pkg.sv ====
// Purpose: types of the converter control block
// Assumes: constants live in acpc_defs.svh
// Notes:   carriers toward the analog core
package acpc_pkg;
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_CONV = 1'b1
   } acpc_state_t;
   typedef struct packed {
      logic [4:0] channel;
      logic [1:0] mode;
      logic       long_sample;
      logic       low_power;
   } acpc_core_ctl_t;
   typedef struct packed {
      logic        done;
      logic [11:0] raw;
   } acpc_core_res_t;
endpackage : acpc_pkg

// ==== hdl/acpc_adc_ctrl.sv ====
// Purpose: register, trigger, clock and pin control of the converter
// Assumes: analog core outside; all inputs synchronous to clk
// Notes:   zero wait AHB-Lite slave, always OKAY
//
// The AHB-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "acpc_defs.svh"
module acpc_adc_ctrl (
   input  wire logic                    clk,
   input  wire logic                    sys_rst,
   input  wire logic                    hsel,
   input  wire logic [31:0]             haddr,
   input  wire logic [1:0]              htrans,
   input  wire logic                    hwrite,
   input  wire logic [2:0]              hsize,
   input  wire logic [31:0]             hwdata,
   input  wire logic                    hready,
   output logic      [31:0]             hrdata,
   output logic                         hreadyout,
   output logic                         hresp,
   input  wire logic                    alternate_clock,
   input  wire logic                    stop_mode,
   input  wire logic                    hw_trigger_input,
   input  wire acpc_pkg::acpc_core_res_t core_res,
   output acpc_pkg::acpc_core_ctl_t     core_ctl,
   output logic                         conv_start,
   output logic                         converter_active,
   output logic                         converter_clock,
   output logic                         irq,
   input  wire logic [15:0]             port_out,
   input  wire logic [15:0]             port_oe_n,
   input  wire logic [15:0]             port_pullup,
   input  wire logic [15:0]             pad_in,
   output logic      [15:0]             pad_out,
   output logic      [15:0]             pad_oe_n,
   output logic      [15:0]             pad_pullup,
   output logic      [15:0]             port_rd
);
   import acpc_pkg::*;

   // bus data phase
   logic [5:0]  dp_addr, next_dp_addr;
   logic        dp_wr, next_dp_wr, rd_res_l, next_rd_res_l;
   logic [31:0] next_hrdata;
   // registers
   logic [4:0]  sc1_ch, next_sc1_ch;
   logic        sc1_cont, irq_en, hwtrig_en, cmp_en, cmp_gt, done_flag;
   logic        next_sc1_cont, next_irq_en, next_hwtrig_en, next_cmp_en, next_cmp_gt, next_done_flag;
   logic [7:0]  cfg, next_cfg, cv_l, next_cv_l, res_l, next_res_l;
   logic [7:0]  pin_mid, next_pin_mid, pin_top, next_pin_top;
   logic [3:0]  cv_h, next_cv_h, res_h, next_res_h;
   // conversion control
   acpc_state_t state, next_state;
   logic        trig_q, next_conv_start, wr_sc1, wr_cfg, disabled, hw_edge, sw_start, abort, pass;
   logic [11:0] rnd, cmpv, diff;
   logic [10:0] sum10;
   logic [8:0]  sum8;
   // clock
   logic        half_q, next_half_q, alt_q, next_conv_clk, src_tick;
   logic [5:0]  osc_cnt, next_osc_cnt;
   logic [2:0]  div_cnt, next_div_cnt, div_lim;
   logic [1:0]  clk_sel, clk_div;
   // pins
   logic [15:0] pin_off, next_pad_out, next_pad_oe_n, next_pad_pullup, next_port_rd;

   assign clk_sel = cfg[1:0];
   assign clk_div = cfg[6:5];

   // bus: reads answered in the data phase, no wait states
   always_comb begin
      logic take;
      take          = hsel & hready & htrans[1];
      next_dp_wr    = take & hwrite;
      next_dp_addr  = haddr[5:0];
      next_rd_res_l = take & ~hwrite & (haddr[5:0] == `A_RES_L);
      next_hrdata   = 32'h0;
      if (take & ~hwrite) begin
         case (haddr[5:0])
            `A_SC1:     next_hrdata[7:0] = {done_flag, irq_en, sc1_cont, sc1_ch};
            `A_SC2:     next_hrdata[7:0] = {converter_active, hwtrig_en, cmp_en, cmp_gt, 4'h0};
            `A_RES_H:   next_hrdata[3:0] = res_h;
            `A_RES_L:   next_hrdata[7:0] = res_l;
            `A_CV_H:    next_hrdata[3:0] = cv_h;
            `A_CV_L:    next_hrdata[7:0] = cv_l;
            `A_CFG:     next_hrdata[7:0] = cfg;
            `A_PIN_MID: next_hrdata[7:0] = pin_mid;
            `A_PIN_TOP: next_hrdata[7:0] = pin_top;
            default:    next_hrdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dp_wr     <= 1'b0;
         dp_addr   <= 6'h00;
         rd_res_l  <= 1'b0;
         hrdata    <= 32'h0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         dp_wr     <= next_dp_wr;
         dp_addr   <= next_dp_addr;
         rd_res_l  <= next_rd_res_l;
         hrdata    <= next_hrdata;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   assign wr_sc1 = dp_wr & (dp_addr == `A_SC1);
   // a write to SC2, config or compare value makes the running conversion invalid
   assign wr_cfg = dp_wr & ((dp_addr == `A_SC2) | (dp_addr == `A_CFG) |
                            (dp_addr == `A_CV_H) | (dp_addr == `A_CV_L));
   assign disabled = (sc1_ch == `CH_OFF) & ~wr_sc1;
   assign hw_edge  = hw_trigger_input & ~trig_q;
   assign sw_start = wr_sc1 & ~hwtrig_en & (hwdata[4:0] != `CH_OFF);
   // stop without the internal clock kills the conversion clock
   assign abort = wr_cfg | disabled | (stop_mode & (clk_sel != `SRC_INT));

   // result rounding and compare
   always_comb begin
      sum10 = {1'b0, core_res.raw[11:2]} + {10'h000, core_res.raw[1]};
      sum8  = {1'b0, core_res.raw[8:1]} + {8'h00, core_res.raw[0]};
      case (core_ctl.mode)
         `RES_12: begin
            rnd  = core_res.raw;
            cmpv = {cv_h, cv_l};
         end
         `RES_10: begin
            rnd  = {2'b00, sum10[10] ? 10'h3ff : sum10[9:0]};
            cmpv = {2'b00, cv_h[1:0], cv_l};
         end
         default: begin
            rnd  = {4'h0, sum8[8] ? 8'hff : sum8[7:0]};
            cmpv = {4'h0, cv_l};
         end
      endcase
      diff = rnd - cmpv;
      pass = ~cmp_en | (cmp_gt ? (rnd >= cmpv) : (rnd < cmpv));
   end

   // registers
   always_comb begin
      logic xfer;
      xfer = (state == ST_CONV) & core_res.done & ~abort & ~wr_sc1 & pass;
      next_sc1_ch    = sc1_ch;
      next_sc1_cont  = sc1_cont;
      next_irq_en    = irq_en;
      next_hwtrig_en = hwtrig_en;
      next_cmp_en    = cmp_en;
      next_cmp_gt    = cmp_gt;
      next_cfg       = cfg;
      next_cv_h      = cv_h;
      next_cv_l      = cv_l;
      next_pin_mid   = pin_mid;
      next_pin_top   = pin_top;
      next_res_h     = res_h;
      next_res_l     = res_l;
      next_done_flag = done_flag;
      if (dp_wr) begin
         case (dp_addr)
            `A_SC1: begin
               next_sc1_ch   = hwdata[4:0];
               next_sc1_cont = hwdata[5];
               next_irq_en   = hwdata[6];
            end
            `A_SC2: begin
               next_hwtrig_en = hwdata[6];
               next_cmp_en    = hwdata[5];
               next_cmp_gt    = hwdata[4];
            end
            `A_CFG:     next_cfg     = hwdata[7:0];
            `A_CV_H:    next_cv_h    = hwdata[3:0];
            `A_CV_L:    next_cv_l    = hwdata[7:0];
            `A_PIN_MID: next_pin_mid = hwdata[7:0];
            `A_PIN_TOP: next_pin_top = hwdata[7:0];
            default:    next_cv_l    = cv_l;
         endcase
      end
      // a read of the low result or a status write clears the flag; a fresh result wins over a read, a status write drops it
      if (wr_sc1 | rd_res_l)
         next_done_flag = 1'b0;
      if (xfer) begin
         next_res_l = cmp_en ? diff[7:0] : rnd[7:0];
         if (core_ctl.mode != `RES_8)
            next_res_h = cmp_en ? diff[11:8] : rnd[11:8];
         next_done_flag = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sc1_ch    <= `CH_OFF;
         sc1_cont  <= 1'b0;
         irq_en    <= 1'b0;
         hwtrig_en <= 1'b0;
         cmp_en    <= 1'b0;
         cmp_gt    <= 1'b0;
         cfg       <= {6'h00, `SRC_BUS};
         cv_h      <= 4'h0;
         cv_l      <= 8'h00;
         res_h     <= 4'h0;
         res_l     <= 8'h00;
         done_flag <= 1'b0;
         pin_mid   <= 8'h00;
         pin_top   <= 8'h00;
         irq       <= 1'b0;
         core_ctl  <= '0;
      end else begin
         sc1_ch    <= next_sc1_ch;
         sc1_cont  <= next_sc1_cont;
         irq_en    <= next_irq_en;
         hwtrig_en <= next_hwtrig_en;
         cmp_en    <= next_cmp_en;
         cmp_gt    <= next_cmp_gt;
         cfg       <= next_cfg;
         cv_h      <= next_cv_h;
         cv_l      <= next_cv_l;
         res_h     <= next_res_h;
         res_l     <= next_res_l;
         done_flag <= next_done_flag;
         pin_mid   <= next_pin_mid;
         pin_top   <= next_pin_top;
         irq       <= next_done_flag & next_irq_en;
         core_ctl  <= '{next_sc1_ch, next_cfg[3:2], next_cfg[4], next_cfg[7]};
      end
   end

   // conversion sequencing; trigger works in every mode but stop without the internal clock
   always_comb begin
      next_state      = state;
      next_conv_start = 1'b0;
      case (state)
         ST_IDLE: begin
            if (sw_start | (hwtrig_en & hw_edge & ~disabled & ~wr_sc1 & ~abort)) begin
               next_state      = ST_CONV;
               next_conv_start = 1'b1;
            end
         end
         ST_CONV: begin
            if (sw_start) begin
               next_conv_start = 1'b1; // restart on status write
            end else if (abort | wr_sc1) begin
               next_state = ST_IDLE;
            end else if (core_res.done) begin
               // a failed compare in single mode simply ends
               if (sc1_cont)
                  next_conv_start = 1'b1;
               else
                  next_state = ST_IDLE;
            end
            // trigger edges are not looked at here
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state            <= ST_IDLE;
         trig_q           <= 1'b0;
         conv_start       <= 1'b0;
         converter_active <= 1'b0;
      end else begin
         state            <= next_state;
         trig_q           <= hw_trigger_input;
         conv_start       <= next_conv_start;
         converter_active <= (next_state == ST_CONV);
      end
   end

   // clock source select and divider
   always_comb begin
      next_half_q  = ~half_q;
      next_osc_cnt = (osc_cnt == 6'(`INT_CLK_CYC - 1)) ? 6'h00 : osc_cnt + 6'h01;
      case (clk_sel)
         `SRC_BUS:  src_tick = ~stop_mode;
         `SRC_HALF: src_tick = ~stop_mode & half_q;
         `SRC_ALT:  src_tick = ~stop_mode & alternate_clock & ~alt_q;
         default:   src_tick = (osc_cnt == 6'h00);
      endcase
      case (clk_div)
         2'b00:   div_lim = 3'd0;
         2'b01:   div_lim = 3'd1;
         2'b10:   div_lim = 3'd3;
         default: div_lim = 3'd7;
      endcase
      next_div_cnt  = div_cnt;
      next_conv_clk = 1'b0;
      // clock stays quiet while idle to save power
      if (!converter_active) begin
         next_div_cnt = 3'd0;
      end else if (src_tick) begin
         if (div_cnt >= div_lim) begin
            next_div_cnt  = 3'd0;
            next_conv_clk = 1'b1;
         end else begin
            next_div_cnt = div_cnt + 3'd1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         half_q          <= 1'b0;
         alt_q           <= 1'b0;
         osc_cnt         <= 6'h00;
         div_cnt         <= 3'd0;
         converter_clock <= 1'b0;
      end else begin
         half_q          <= next_half_q;
         alt_q           <= alternate_clock;
         osc_cnt         <= next_osc_cnt;
         div_cnt         <= next_div_cnt;
         converter_clock <= next_conv_clk;
      end
   end

   // pin control, channel 8 at bit 0 up to channel 23 at bit 15
   assign pin_off = {pin_top, pin_mid};

   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++) begin : g_pin
         assign next_pad_out[gi]    = port_out[gi] & ~pin_off[gi];
         assign next_pad_oe_n[gi]   = port_oe_n[gi] | pin_off[gi];
         assign next_pad_pullup[gi] = port_pullup[gi] & ~pin_off[gi];
         assign next_port_rd[gi]    = pad_in[gi] & ~pin_off[gi];
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pad_out    <= 16'h0000;
         pad_oe_n   <= 16'hffff;
         pad_pullup <= 16'h0000;
         port_rd    <= 16'h0000;
      end else begin
         pad_out    <= next_pad_out;
         pad_oe_n   <= next_pad_oe_n;
         pad_pullup <= next_pad_pullup;
         port_rd    <= next_port_rd;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   disabled_held_idle_a : assert property (
      (sc1_ch == `CH_OFF && !wr_sc1) |=> !converter_active)
      else $error("converter active while channel select is off");

   single_done_idle_a : assert property (
      (state == ST_CONV && core_res.done && !sc1_cont && !wr_sc1) |=> !converter_active && !conv_start)
      else $error("converter not idle after single conversion");

   done_raises_irq_a : assert property (
      ($rose(done_flag) && irq_en) |-> irq)
      else $error("done flag set without interrupt");

   busy_edge_ignored_a : assert property (
      (state == ST_CONV && hw_edge && !wr_sc1 && !core_res.done) |=> !conv_start)
      else $error("trigger edge restarted a busy conversion");

   bus_div_one_a : assert property (
      (converter_active && clk_sel == `SRC_BUS && clk_div == 2'b00 && !stop_mode && div_cnt == 3'd0)
      |=> converter_clock)
      else $error("undivided bus clock missed a tick");

   half_div_sixteen_a : assert property (
      (converter_clock && clk_sel == `SRC_HALF && clk_div == `DIV_8) |=> !converter_clock [*8])
      else $error("halved clock with divide 8 ticked too early");

   pin_hiz_a : assert property (
      ##1 ((pad_oe_n | ~$past(pin_off)) == 16'hffff))
      else $error("disabled pin still driven");

   pin_read_zero_a : assert property (
      ##1 ((port_rd & $past(pin_off)) == 16'h0000))
      else $error("disabled pin reads non-zero");

   pullup_off_a : assert property (
      ##1 ((pad_pullup & $past(pin_off)) == 16'h0000))
      else $error("pull-up on for disabled pin");

endmodule : acpc_adc_ctrl

// ==== verif/test_adc_control_pin_clock_trigger.sv ====
// Purpose: self-checking bench of the converter control block
// Assumes: zero-wait bus slave; the bench plays the analog core
// Notes:   tick gaps are counted in clk cycles
`timescale 1ns/100ps
`include "acpc_defs.svh"
module test_adc_control_pin_clock_trigger;
   import acpc_pkg::*;
   logic           clk, sys_rst, hsel, hwrite, hready, hreadyout, hresp;
   logic           alternate_clock, stop_mode, hw_trigger_input;
   logic           conv_start, converter_active, converter_clock, irq;
   logic [31:0]    haddr, hwdata, hrdata, rd;
   logic [1:0]     htrans;
   logic [2:0]     hsize;
   logic [15:0]    port_out, port_oe_n, port_pullup, pad_in, pad_out, pad_oe_n, pad_pullup, port_rd;
   acpc_core_res_t core_res;
   acpc_core_ctl_t core_ctl;
   int             num_errors = 0, compares = 0, n_start = 0, ticks = 0, cyc = 0;
   int             last_tick = 0, gap = 0, n0 = 0, t0 = 0, k = 0;

   assign hready = hreadyout;

   acpc_adc_ctrl acpc_adc_ctrl_i (
      .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .alternate_clock(alternate_clock),
      .stop_mode(stop_mode), .hw_trigger_input(hw_trigger_input), .core_res(core_res),
      .core_ctl(core_ctl), .conv_start(conv_start), .converter_active(converter_active),
      .converter_clock(converter_clock), .irq(irq), .port_out(port_out), .port_oe_n(port_oe_n),
      .port_pullup(port_pullup), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
      .pad_pullup(pad_pullup), .port_rd(port_rd));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // alternate source: one rising edge every 6 cycles
   initial begin
      alternate_clock = 1'b0;
      forever begin
         repeat (3) @(posedge clk);
         alternate_clock <= ~alternate_clock;
      end
   end

   // counts start pulses and the gap between converter clock ticks
   always @(posedge clk) begin
      cyc++;
      if (conv_start === 1'b1) n_start++;
      if (converter_clock === 1'b1) begin
         gap = cyc - last_tick;
         last_tick = cyc;
         ticks++;
      end
   end

   task end_of_test;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_of_test

   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // address phase, then data phase; each held until hready is seen high
   task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask : bus

   task wr(input logic [31:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task rdchk(input string name, input logic [31:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(name, rd, exp);
   endtask : rdchk

   task go(input logic [7:0] cfg, input logic [7:0] sc);
      wr(`A_CFG, {24'h0, cfg});
      n0 = n_start;
      wr(`A_SC1, {24'h0, sc});
   endtask : go

   // bounded wait for the expected number of start pulses, then a settle
   task starts(input int exp, input int span);
      k = 0;
      while (n_start - n0 < exp && k < span) begin
         @(posedge clk);
         k++;
      end
      repeat (2) @(posedge clk);
      check("conv_start count", n_start - n0, exp);
   endtask : starts

   task done(input logic [11:0] raw);
      core_res <= '{done: 1'b1, raw: raw};
      @(posedge clk);
      core_res <= '0;
      repeat (3) @(posedge clk);
   endtask : done

   task trig;
      hw_trigger_input <= 1'b0;
      @(posedge clk);
      hw_trigger_input <= 1'b1;
      @(posedge clk);
   endtask : trig

   // first gaps may span an idle stretch, so judge the third tick
   task measure(input int exp);
      t0 = ticks;
      k = 0;
      while (ticks - t0 < 3 && k < 400) begin
         @(posedge clk);
         k++;
      end
      check("tick gap", gap, exp);
   endtask : measure

   task abort_run;
      wr(`A_SC1, 32'h1f);
      repeat (2) @(posedge clk);
      check("active after off", converter_active, 1'b0);
   endtask : abort_run

   task t_reset;
      check("active in reset", converter_active, 1'b0);
      check("hresp", hresp, 1'b0);
      check("hready", hreadyout, 1'b1);
      rdchk("status", `A_SC1, 32'h1f);
      rdchk("config", `A_CFG, 32'h0);
      rdchk("pin mid", `A_PIN_MID, 32'h0);
      rdchk("pin top", `A_PIN_TOP, 32'h0);
      rdchk("unmapped", 32'h3c, 32'h0);
      check("pad oe", pad_oe_n, 16'h0000);
   endtask : t_reset

   task t_pins;
      wr(`A_PIN_MID, 32'ha5);
      wr(`A_PIN_TOP, 32'h3c);
      rdchk("pin mid", `A_PIN_MID, 32'ha5);
      rdchk("pin top", `A_PIN_TOP, 32'h3c);
      repeat (2) @(posedge clk);
      check("pad oe", pad_oe_n, 16'h3ca5);
      check("pad out", pad_out, 16'hc35a);
      check("pullup", pad_pullup, 16'hc35a);
      check("port read", port_rd, 16'hc35a);
      wr(`A_PIN_MID, 32'h0);
      wr(`A_PIN_TOP, 32'h0);
      repeat (2) @(posedge clk);
      check("pad out back", pad_out, 16'hffff);
   endtask : t_pins

   task t_conv;
      go(8'h04, 8'h43);
      starts(1, 8);
      check("active", converter_active, 1'b1);
      check("core ctl", core_ctl, 32'h034);
      done(12'habc);
      check("irq", irq, 1'b1);
      check("idle", converter_active, 1'b0);
      rdchk("status", `A_SC1, 32'hc3);
      rdchk("res hi 12", `A_RES_H, 32'h0a);
      rdchk("res lo 12", `A_RES_L, 32'hbc);
      repeat (2) @(posedge clk);
      check("irq cleared", irq, 1'b0);
      go(8'h08, 8'h03);
      starts(1, 8);
      done(12'h807);
      rdchk("res hi 10", `A_RES_H, 32'h02);
      rdchk("res lo 10", `A_RES_L, 32'h02);
      go(8'h00, 8'h03);
      starts(1, 8);
      done(12'h1fe);
      rdchk("res hi kept", `A_RES_H, 32'h02);
      rdchk("res lo 8", `A_RES_L, 32'hff);
   endtask : t_conv

   task t_cmp;
      wr(`A_CV_H, 32'h1);
      wr(`A_CV_L, 32'h0);
      wr(`A_SC2, 32'h30);
      go(8'h04, 8'h03);
      starts(1, 8);
      done(12'h0ff);
      rdchk("flag below", `A_SC1, 32'h03);
      go(8'h04, 8'h03);
      starts(1, 8);
      done(12'h150);
      rdchk("flag above", `A_SC1, 32'h83);
      rdchk("diff hi", `A_RES_H, 32'h0);
      rdchk("diff lo", `A_RES_L, 32'h50);
      wr(`A_SC2, 32'h20);
      go(8'h04, 8'h03);
      starts(1, 8);
      done(12'h0ff);
      rdchk("low limit hi", `A_RES_H, 32'h0f);
      rdchk("low limit lo", `A_RES_L, 32'hff);
      wr(`A_SC2, 32'h0);
   endtask : t_cmp

   task t_clk;
      for (int d = 0; d < 4; d++) begin
         go({1'b0, d[1:0], 5'b00100}, 8'h03);
         measure(1 << d);
         abort_run;
      end
      go(8'h65, 8'h03);
      measure(16);
      abort_run;
      go(8'h06, 8'h03);
      measure(6);
      abort_run;
      go(8'h07, 8'h03);
      measure(`INT_CLK_CYC);
      stop_mode <= 1'b1;
      measure(`INT_CLK_CYC);
      check("active in stop", converter_active, 1'b1);
      stop_mode <= 1'b0;
      abort_run;
      go(8'h04, 8'h03);
      stop_mode <= 1'b1;
      repeat (3) @(posedge clk);
      check("stop aborts bus run", converter_active, 1'b0);
      stop_mode <= 1'b0;
      @(posedge clk);
   endtask : t_clk

   task t_hw;
      wr(`A_SC2, 32'h40);
      go(8'h04, 8'h03);
      starts(0, 6);
      trig;
      starts(1, 6);
      n0 = n_start;
      trig;
      starts(0, 4);
      check("still active", converter_active, 1'b1);
      done(12'h123);
      rdchk("hw res lo", `A_RES_L, 32'h23);
      go(8'h08, 8'h23);
      trig;
      starts(1, 6);
      n0 = n_start;
      done(12'h456);
      starts(1, 6);
      n0 = n_start;
      trig;
      starts(0, 6);
      wr(`A_PIN_TOP, 32'h81);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      check("active in reset", converter_active, 1'b0);
      check("pad oe in reset", pad_oe_n, 16'hffff);
      sys_rst <= 1'b0;
      @(posedge clk);
      rdchk("pin top after reset", `A_PIN_TOP, 32'h0);
      rdchk("status after reset", `A_SC1, 32'h1f);
      abort_run;
      wr(`A_SC2, 32'h0);
   endtask : t_hw

   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      end_of_test;
   end

   initial begin
      sys_rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      stop_mode = 1'b0;
      hw_trigger_input = 1'b0;
      core_res = '0;
      port_out = 16'hffff;
      port_oe_n = 16'h0000;
      port_pullup = 16'hffff;
      pad_in = 16'hffff;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      t_reset;
      t_pins;
      t_conv;
      t_cmp;
      t_clk;
      t_hw;
      end_of_test;
   end
endmodule : test_adc_control_pin_clock_trigger
